// ==== hw/prcl_i2c_slave.sv ====
`timescale 1ns/1ps
module prcl_i2c_slave
    import prcl_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       clk_en,
    input  wire logic       scl_s,
    input  wire logic       sda_s,
    output logic            sda_oe_n,
    output logic [7:0]      reg_addr,
    output logic [7:0]      wr_data,
    output logic            wr_stb,
    input  wire logic [7:0] rd_data
);
    typedef enum logic [2:0] {PRCL_IDLE, PRCL_DEVADR, PRCL_REGADR, PRCL_WDATA,
                              PRCL_RDATA, PRCL_ACK, PRCL_MACK} prcl_st_t;
    prcl_st_t    st_r, st_nxt, ret_r, ret_nxt;
    logic        scl_d_r, sda_d_r, oe_n_r, oe_n_nxt, stb_r, stb_nxt;
    logic [3:0]  cnt_r, cnt_nxt;
    logic [7:0]  sh_r, sh_nxt, adr_r, adr_nxt, wd_r, wd_nxt;
    logic        rise, fall, start, stop;

    assign rise  = scl_s & ~scl_d_r;
    assign fall  = ~scl_s & scl_d_r;
    assign start = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    always_comb begin
        st_nxt = st_r; ret_nxt = ret_r; oe_n_nxt = oe_n_r;
        cnt_nxt = cnt_r; sh_nxt = sh_r; adr_nxt = adr_r; wd_nxt = wd_r;
        stb_nxt = 1'b0;
        if (start) begin
            st_nxt = PRCL_DEVADR; cnt_nxt = 4'h0; oe_n_nxt = 1'b1;
        end else if (stop) begin
            st_nxt = PRCL_IDLE; oe_n_nxt = 1'b1;
        end else begin
            unique case (st_r)
                PRCL_IDLE: ;
                PRCL_DEVADR, PRCL_REGADR, PRCL_WDATA: begin
                    if (rise) begin
                        sh_nxt = {sh_r[6:0], sda_s};
                        cnt_nxt = cnt_r + 4'h1;
                    end
                    if (fall && cnt_r == 4'h8) begin
                        cnt_nxt = 4'h0;
                        ret_nxt = PRCL_IDLE;
                        if (st_r == PRCL_DEVADR) begin
                            if (sh_r[7:1] == PRCL_SLAVE_ADDR) begin
                                ret_nxt = sh_r[0] ? PRCL_RDATA : PRCL_REGADR;
                            end
                        end else if (st_r == PRCL_REGADR) begin
                            adr_nxt = sh_r;
                            ret_nxt = PRCL_WDATA;
                        end else begin
                            wd_nxt = sh_r;
                            stb_nxt = 1'b1;
                            ret_nxt = PRCL_WDATA;
                        end
                        // Ack every byte except a device address that does not match, protected or not
                        oe_n_nxt = (ret_nxt == PRCL_IDLE);
                        st_nxt = (ret_nxt == PRCL_IDLE) ? PRCL_IDLE : PRCL_ACK;
                        if (ret_nxt == PRCL_RDATA) begin
                            st_nxt = PRCL_ACK;
                        end
                    end
                end
                PRCL_ACK: begin
                    // Step past the byte whose write strobe is out in this same cycle
                    if (stb_r) adr_nxt = adr_r + 8'h01;
                    if (fall) begin
                        st_nxt = ret_r;
                        if (ret_r == PRCL_RDATA) begin
                            sh_nxt = rd_data;
                            oe_n_nxt = rd_data[7];
                            cnt_nxt = 4'h1;
                        end else begin
                            oe_n_nxt = 1'b1;
                        end
                    end
                end
                PRCL_RDATA: begin
                    if (fall) begin
                        if (cnt_r == 4'h8) begin
                            oe_n_nxt = 1'b1;
                            st_nxt = PRCL_MACK;
                            adr_nxt = adr_r + 8'h01;
                        end else begin
                            oe_n_nxt = sh_r[7 - cnt_r[2:0]];
                            cnt_nxt = cnt_r + 4'h1;
                        end
                    end
                end
                PRCL_MACK: begin
                    if (rise) st_nxt = sda_s ? PRCL_IDLE : PRCL_ACK;
                    ret_nxt = PRCL_RDATA;
                end
                default: st_nxt = PRCL_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_r <= PRCL_IDLE; ret_r <= PRCL_IDLE; oe_n_r <= 1'b1;
            cnt_r <= 4'h0; sh_r <= 8'h00; adr_r <= 8'h00; wd_r <= 8'h00;
            stb_r <= 1'b0; scl_d_r <= 1'b1; sda_d_r <= 1'b1;
        end else if (clk_en) begin
            st_r <= st_nxt; ret_r <= ret_nxt; oe_n_r <= oe_n_nxt;
            cnt_r <= cnt_nxt; sh_r <= sh_nxt; adr_r <= adr_nxt; wd_r <= wd_nxt;
            stb_r <= stb_nxt; scl_d_r <= scl_s; sda_d_r <= sda_s;
        end
    end

    assign sda_oe_n = oe_n_r;
    assign reg_addr = adr_r;
    assign wr_data  = wd_r;
    assign wr_stb   = stb_r & clk_en;
endmodule // prcl_i2c_slave

// ==== hw/prcl_pkg.sv ====
package prcl_pkg;
    localparam logic [7:0] PRCL_ADDR_REMAP3    = 8'hFC;
    localparam logic [7:0] PRCL_ADDR_STATCMD   = 8'hFF;
    localparam logic [7:0] PRCL_REMAP3_RESET   = 8'h03;
    localparam logic [1:0] PRCL_DEFAULT_LPORT3 = 2'h3;
    localparam logic [3:0] PRCL_CODE_MAX       = 4'h3;
    localparam int         PRCL_BIT_SOFTRST    = 1;
    localparam int         PRCL_BIT_PROTECT    = 0;
    localparam logic [6:0] PRCL_SLAVE_ADDR     = 7'h08;
    localparam logic [7:0] PRCL_PROT_LO_END    = 8'hE1;
    localparam logic [7:0] PRCL_PROT_HI_BEGIN  = 8'hEF;
endpackage

// ==== hw/prcl_regs.sv ====
`timescale 1ns/1ps
module prcl_regs
    import prcl_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       clk_en,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic       remap_mode_enable,
    output logic            port3_enabled,
    output logic [1:0]      port3_logical,
    output logic            cfg_wr_en,
    output logic [7:0]      port_three_remap,
    output logic            config_protect,
    output logic            soft_reset_pulse
);
    logic [1:0] scl_sy_r, sda_sy_r;
    logic [7:0] remap_r, remap_nxt, addr, wdata, rdata;
    logic       prot_r, prot_nxt, srst_r, srst_nxt, wstb, wr_ok;
    logic       en_r, en_nxt;
    logic [1:0] lp_r, lp_nxt;

    function automatic logic prcl_protected(input logic [7:0] a);
        return (a <= PRCL_PROT_LO_END) || (a >= PRCL_PROT_HI_BEGIN);
    endfunction

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            scl_sy_r <= 2'h3;
            sda_sy_r <= 2'h3;
        end else if (clk_en) begin
            scl_sy_r <= {scl_sy_r[0], scl_in};
            sda_sy_r <= {sda_sy_r[0], sda_in};
        end
    end

    prcl_i2c_slave u_slave (
        .clk_sys  (clk_sys),
        .reset    (reset | srst_r),
        .clk_en   (clk_en),
        .scl_s    (scl_sy_r[1]),
        .sda_s    (sda_sy_r[1]),
        .sda_oe_n (sda_oe_n),
        .reg_addr (addr),
        .wr_data  (wdata),
        .wr_stb   (wstb),
        .rd_data  (rdata)
    );

    // Protected writes are dropped silently, except the soft-reset bit of a write to the status/command register
    assign wr_ok = wstb & ~(prot_r & prcl_protected(addr));

    always_comb begin
        remap_nxt = remap_r;
        prot_nxt  = prot_r;
        srst_nxt  = 1'b0;
        if (srst_r) begin
            remap_nxt = PRCL_REMAP3_RESET;
        end else if (wr_ok) begin
            if (addr == PRCL_ADDR_REMAP3) remap_nxt = wdata;
            if (addr == PRCL_ADDR_STATCMD) begin
                srst_nxt = wdata[PRCL_BIT_SOFTRST];
                prot_nxt = prot_r | wdata[PRCL_BIT_PROTECT];
            end
        end
        if (wstb && !wr_ok && addr == PRCL_ADDR_STATCMD) srst_nxt = wdata[PRCL_BIT_SOFTRST];
    end

    always_comb begin
        en_nxt = 1'b1;
        lp_nxt = PRCL_DEFAULT_LPORT3;
        if (remap_mode_enable) begin
            if (remap_r[3:0] == 4'h0 || remap_r[3:0] > PRCL_CODE_MAX) begin
                en_nxt = 1'b0;
                lp_nxt = 2'h0;
            end else begin
                lp_nxt = remap_r[1:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            remap_r <= PRCL_REMAP3_RESET;
            prot_r  <= 1'b0;
            srst_r  <= 1'b0;
            en_r    <= 1'b1;
            lp_r    <= PRCL_DEFAULT_LPORT3;
        end else if (clk_en) begin
            remap_r <= remap_nxt;
            prot_r  <= prot_nxt;
            srst_r  <= srst_nxt;
            en_r    <= en_nxt;
            lp_r    <= lp_nxt;
        end
    end

    always_comb begin
        unique case (addr)
            PRCL_ADDR_REMAP3:  rdata = remap_r;
            PRCL_ADDR_STATCMD: rdata = {6'h00, 1'b0, prot_r};
            default:           rdata = 8'h00;
        endcase
    end

    assign sda_out          = 1'b0;
    assign port3_enabled    = en_r;
    assign port3_logical    = lp_r;
    assign cfg_wr_en        = ~prot_r;
    assign port_three_remap = remap_r;
    assign config_protect   = prot_r;
    assign soft_reset_pulse = srst_r;

    property p_reset_val;
        @(posedge clk_sys) $fell(reset) |-> remap_r == PRCL_REMAP3_RESET;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("remap reset value wrong");

    property p_disable;
        @(posedge clk_sys) disable iff (reset)
        clk_en && remap_mode_enable && remap_r[3:0] == 4'h0 |=> !en_r;
    endproperty
    a_disable: assert property (p_disable) else $error("port 3 not disabled");

    property p_map;
        @(posedge clk_sys) disable iff (reset)
        clk_en && remap_mode_enable && remap_r[3:0] inside {4'h1, 4'h2, 4'h3}
        |=> en_r && lp_r == $past(remap_r[1:0]);
    endproperty
    a_map: assert property (p_map) else $error("logical port mismatch");

    property p_rsvd;
        @(posedge clk_sys) disable iff (reset)
        clk_en && remap_mode_enable && remap_r[3:0] > 4'h3 |=> !en_r;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved code not disabled");

    property p_nomap;
        @(posedge clk_sys) disable iff (reset)
        clk_en && !remap_mode_enable |=> en_r && lp_r == PRCL_DEFAULT_LPORT3;
    endproperty
    a_nomap: assert property (p_nomap) else $error("default numbering lost");

    sequence s_soft;
        clk_en && srst_r;
    endsequence
    property p_soft;
        @(posedge clk_sys) disable iff (reset)
        s_soft |=> remap_r == PRCL_REMAP3_RESET && !srst_r;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset incomplete");

    property p_prot;
        @(posedge clk_sys) disable iff (reset)
        prot_r && !srst_r && clk_en |=> remap_r == $past(remap_r);
    endproperty
    a_prot: assert property (p_prot) else $error("protected write took effect");

    property p_once;
        @(posedge clk_sys) disable iff (reset) prot_r |=> prot_r;
    endproperty
    a_once: assert property (p_once) else $error("protect bit cleared");

    property p_inc;
        @(posedge clk_sys) disable iff (reset)
        clk_en && wstb |=> addr == $past(addr) + 8'h01;
    endproperty
    a_inc: assert property (p_inc) else $error("address not incremented");
endmodule // prcl_regs

// ==== test/port_remap_and_config_lock_regs_bench.sv ====
`timescale 1ns/1ps
module port_remap_and_config_lock_regs_bench;
    import prcl_pkg::*;
    logic       clk_sys, reset, remap_mode_enable, scl, sda_m, sda_out, sda_oe_n;
    logic       port3_enabled, cfg_wr_en, config_protect, soft_reset_pulse;
    logic [1:0] port3_logical;
    logic [7:0] port_three_remap;
    wire        sda_line = sda_m & (sda_oe_n | sda_out);
    int         err_total = 0;
    int         check_count = 0;
    int         sr_cnt = 0;
    prcl_regs dut_u (.clk_sys(clk_sys), .reset(reset), .clk_en(1'b1), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .remap_mode_enable(remap_mode_enable), .port3_enabled(port3_enabled),
        .port3_logical(port3_logical), .cfg_wr_en(cfg_wr_en),
        .port_three_remap(port_three_remap), .config_protect(config_protect),
        .soft_reset_pulse(soft_reset_pulse));
    prcl_i2c_master mst_u (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda(sda_m));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) if (soft_reset_pulse === 1'b1) sr_cnt++;
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_port(input logic en, input logic [1:0] lg);
        chk("port3_enabled", {7'h0, en}, {7'h0, port3_enabled});
        chk("port3_logical", {6'h0, lg}, {6'h0, port3_logical});
    endtask
    task automatic wr1(input logic [7:0] ra, input logic [7:0] d);
        mst_u.buf_q[0] = d;
        mst_u.wr(ra, 1);
    endtask
    task automatic final_report();
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #5_000_000;
        err_total++;
        final_report();
    end
    initial begin
        reset = 1'b1;
        remap_mode_enable = 1'b0;
        repeat (5) @(negedge clk_sys);
        reset = 1'b0;
        chk("remap", 8'h03, port_three_remap);
        chk_port(1'b1, 2'h3);
        mst_u.rd(PRCL_ADDR_REMAP3, 4);
        chk("rd_remap", 8'h03, mst_u.buf_q[0]);
        chk("rd_unmapped", 8'h00, mst_u.buf_q[1]);
        chk("rd_unmapped", 8'h00, mst_u.buf_q[2]);
        chk("rd_status", 8'h00, mst_u.buf_q[3]);
        remap_mode_enable = 1'b1;
        for (int c = 0; c < 16; c++) begin
            wr1(PRCL_ADDR_REMAP3, 8'(c));
            chk("remap", 8'(c), port_three_remap);
            chk_port(c >= 1 && c <= 3, (c >= 1 && c <= 3) ? 2'(c) : 2'h0);
        end
        remap_mode_enable = 1'b0;
        wr1(PRCL_ADDR_REMAP3, 8'h02);
        chk_port(1'b1, 2'h3);
        remap_mode_enable = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk_port(1'b1, 2'h2);
        wr1(PRCL_ADDR_STATCMD, 8'h02);
        chk("remap", 8'h03, port_three_remap);
        chk("sr_pulses", 8'h01, 8'(sr_cnt));
        mst_u.rd(PRCL_ADDR_STATCMD, 1);
        chk("rd_status", 8'h00, mst_u.buf_q[0]);
        mst_u.buf_q[0] = 8'h00;
        mst_u.buf_q[1] = 8'h01;
        mst_u.wr(8'hFE, 2);
        chk("protect", 8'h01, {7'h0, config_protect});
        chk("cfg_wr_en", 8'h00, {7'h0, cfg_wr_en});
        wr1(PRCL_ADDR_REMAP3, 8'h01);
        mst_u.rd(PRCL_ADDR_REMAP3, 1);
        chk("rd_remap", 8'h03, mst_u.buf_q[0]);
        wr1(PRCL_ADDR_STATCMD, 8'h00);
        chk("protect", 8'h01, {7'h0, config_protect});
        wr1(PRCL_ADDR_STATCMD, 8'h02);
        chk("sr_pulses", 8'h02, 8'(sr_cnt));
        chk("protect", 8'h01, {7'h0, config_protect});
        mst_u.rd(PRCL_ADDR_STATCMD, 1);
        chk("rd_status", 8'h01, mst_u.buf_q[0]);
        reset = 1'b1;
        @(negedge clk_sys);
        reset = 1'b0;
        chk("protect", 8'h00, {7'h0, config_protect});
        wr1(PRCL_ADDR_REMAP3, 8'h01);
        chk("remap", 8'h01, port_three_remap);
        // Each soft reset drops the slave before its ack stands
        chk("nacks", 8'h02, 8'(mst_u.nack_cnt));
        final_report();
    end
endmodule // port_remap_and_config_lock_regs_bench

// ==== test/prcl_i2c_master.sv ====
`timescale 1ns/1ps
module prcl_i2c_master
    import prcl_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda
);
    logic [7:0] buf_q [4];
    int         nack_cnt = 0;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic hp();
        repeat (12) @(negedge clk_sys);
    endtask
    task automatic bit_io(input logic b, output logic s);
        sda = b;
        hp();
        scl = 1'b1;
        hp();
        s = sda_line;
        scl = 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] d, input logic mack, output logic [7:0] q,
                           output logic s);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(mack, s);
    endtask
    task automatic start();
        sda = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        sda = 1'b0;
        hp();
        scl = 1'b0;
    endtask
    task automatic stop();
        sda = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        sda = 1'b1;
        hp();
    endtask
    task automatic send(input logic [7:0] d);
        logic [7:0] q;
        logic       s;
        byte_io(d, 1'b1, q, s);
        if (s !== 1'b0) nack_cnt++;
    endtask
    task automatic wr(input logic [7:0] ra, input int n);
        start();
        send({PRCL_SLAVE_ADDR, 1'b0});
        send(ra);
        for (int k = 0; k < n; k++) send(buf_q[k]);
        stop();
    endtask
    task automatic rd(input logic [7:0] ra, input int n);
        logic s;
        start();
        send({PRCL_SLAVE_ADDR, 1'b0});
        send(ra);
        start();
        send({PRCL_SLAVE_ADDR, 1'b1});
        for (int k = 0; k < n; k++) byte_io(8'hFF, k == n - 1, buf_q[k], s);
        stop();
    endtask
endmodule // prcl_i2c_master
